// ==== tmcc_map.svh ====
`ifndef TMCC_MAP_SVH
`define TMCC_MAP_SVH
`define TMCC_ADDR_W 4
`define TMCC_OFF_MODE 4'h0
`define TMCC_OFF_CAPCTL 4'h1
`define TMCC_OFF_OUTCTL 4'h2
`define TMCC_OFF_PRESC 4'h3
`define TMCC_OFF_CMPA 4'h4
`define TMCC_OFF_CMPB 4'h5
`define TMCC_OFF_COUNT 4'h6
`define TMCC_OFF_IRQ_STAT 4'h7
`define TMCC_OFF_IRQ_MASK 4'h8
`define TMCC_MODE_OVF_BIT 0
`define TMCC_MODE_OP_LO_BIT 2
`define TMCC_MODE_OP_HI_BIT 3
`define TMCC_OUT_ENABLE_BIT 0
`define TMCC_OUT_MODE_BIT 1
`define TMCC_OUT_FSET_BIT 2
`define TMCC_OUT_FRESET_BIT 3
`define TMCC_OUT_TRIG_SEL_BIT 4
`define TMCC_OUT_OS_EN_BIT 5
`define TMCC_OUT_SW_TRIG_BIT 6
`define TMCC_CAP_A_BIT 0
`define TMCC_CAP_B_BIT 1
`define TMCC_PRESC_CLK_LSB 0
`define TMCC_PRESC_EDGE_LSB 4
`define TMCC_COUNT_MAX 16'hFFFF
`define TMCC_COUNT_ZERO 16'h0000
`define TMCC_IRQ_OVF_BIT 0
`define TMCC_IRQ_MATCH_A_BIT 1
`define TMCC_IRQ_MATCH_B_BIT 2
`define TMCC_IRQ_CAP_BIT 3
`endif

// ==== tmcc_pkg.sv ====
`default_nettype none
package tmcc_pkg;
  typedef enum logic [1:0] {
    TMCC_OP_STOP,
    TMCC_OP_CLR_EDGE,
    TMCC_OP_FREE,
    TMCC_OP_CLR_MATCH
  } tmcc_op_type;
  typedef enum logic [1:0] {
    TMCC_EDGE_FALL,
    TMCC_EDGE_RISE,
    TMCC_EDGE_NONE,
    TMCC_EDGE_BOTH
  } tmcc_edge_type;
endpackage
`default_nettype wire

// ==== tmcc_timer.sv ====
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tmcc_map.svh"
module tmcc_timer
  import tmcc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`TMCC_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic internal_ring_oscillator_sel,
  input wire logic ext_edge_input_a,
  output logic shared_port_pin,
  output logic irq
);
  logic [7:0] mode_ctrl_reg, mode_ctrl_next;
  logic [7:0] capture_ctrl_reg, capture_ctrl_next;
  logic [7:0] output_ctrl_reg, output_ctrl_next;
  logic [7:0] prescaler_mode_reg, prescaler_mode_next;
  logic [CNT_W-1:0] compare_reg_a, compare_a_next;
  logic [CNT_W-1:0] compare_reg_b, compare_b_next;
  logic [CNT_W-1:0] count_value, count_next;
  logic [3:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [7:0] div_reg, div_next;
  logic [2:0] in_sync_reg;
  logic out_ff_reg, out_ff_next, os_active_reg, os_active_next;
  logic tick, edge_hit, rise, fall, running, wrap, match_a, match_b;
  logic sw_oneshot_trigger;
  logic [2:0] div_sel;
  tmcc_op_type op;
  tmcc_edge_type edge_sel;

  assign op = tmcc_op_type'(mode_ctrl_reg[`TMCC_MODE_OP_HI_BIT:`TMCC_MODE_OP_LO_BIT]);
  assign running = (op != TMCC_OP_STOP);
  assign edge_sel = tmcc_edge_type'(prescaler_mode_reg[`TMCC_PRESC_EDGE_LSB +: 2]);
  assign div_sel = prescaler_mode_reg[`TMCC_PRESC_CLK_LSB +: 3];
  assign rise = in_sync_reg[1] & ~in_sync_reg[2];
  assign fall = ~in_sync_reg[1] & in_sync_reg[2];
  always_comb begin
    case (edge_sel)
      TMCC_EDGE_FALL: edge_hit = fall;
      TMCC_EDGE_RISE: edge_hit = rise;
      TMCC_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  end
  // Ring clock is the same source here; prescale divides by 2 to the power div_sel, except that setting 7 with ring select ticks every clock
  assign div_next = running ? div_reg + 8'h01 : 8'h00;
  assign tick = running && (div_sel == 3'h0 || (internal_ring_oscillator_sel && div_sel == 3'h7) ? 1'b1 :
                (div_reg & ((8'h01 << div_sel) - 8'h01)) == 8'h00);
  assign wrap = tick && count_value == `TMCC_COUNT_MAX;
  assign match_a = tick && count_value == compare_reg_a;
  assign match_b = tick && count_value == compare_reg_b;
  assign sw_oneshot_trigger = wr && addr == `TMCC_OFF_OUTCTL && wdata[`TMCC_OUT_SW_TRIG_BIT];

  always_comb begin
    mode_ctrl_next = mode_ctrl_reg;
    capture_ctrl_next = capture_ctrl_reg;
    output_ctrl_next = output_ctrl_reg;
    prescaler_mode_next = prescaler_mode_reg;
    compare_a_next = compare_reg_a;
    compare_b_next = compare_reg_b;
    count_next = count_value;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    out_ff_next = out_ff_reg;
    os_active_next = os_active_reg;
    rdata_next = 16'h0000;
    if (wr) begin
      if (addr == `TMCC_OFF_MODE) begin
        mode_ctrl_next = wdata[7:0];
        mode_ctrl_next[1] = 1'b0;
      end else if (addr == `TMCC_OFF_CAPCTL) begin
        capture_ctrl_next = wdata[7:0];
      end else if (addr == `TMCC_OFF_OUTCTL) begin
        output_ctrl_next = wdata[7:0];
        output_ctrl_next[`TMCC_OUT_FSET_BIT] = 1'b0;
        output_ctrl_next[`TMCC_OUT_FRESET_BIT] = 1'b0;
        output_ctrl_next[`TMCC_OUT_SW_TRIG_BIT] = 1'b0;
        if (wdata[`TMCC_OUT_FSET_BIT] && output_ctrl_reg[`TMCC_OUT_ENABLE_BIT]) begin
          out_ff_next = 1'b1;
        end else if (wdata[`TMCC_OUT_FRESET_BIT]) begin
          out_ff_next = 1'b0;
        end
      end else if (addr == `TMCC_OFF_PRESC) begin
        prescaler_mode_next = wdata[7:0];
      end else if (addr == `TMCC_OFF_CMPA) begin
        compare_a_next = wdata[CNT_W-1:0];
      end else if (addr == `TMCC_OFF_CMPB) begin
        compare_b_next = wdata[CNT_W-1:0];
      end else if (addr == `TMCC_OFF_IRQ_MASK) begin
        irq_mask_next = wdata[3:0];
      end
    end
    // One-shot trigger honoured only in one-shot mode
    if (sw_oneshot_trigger && output_ctrl_reg[`TMCC_OUT_OS_EN_BIT]) begin
      os_active_next = 1'b1;
      count_next = `TMCC_COUNT_ZERO;
    end else if (!running) begin
      count_next = `TMCC_COUNT_ZERO;
      os_active_next = 1'b0;
    end else if (op == TMCC_OP_CLR_EDGE && edge_hit) begin
      count_next = `TMCC_COUNT_ZERO;
    end else if (tick) begin
      if (op == TMCC_OP_CLR_MATCH && match_a && !capture_ctrl_reg[`TMCC_CAP_A_BIT]) begin
        count_next = `TMCC_COUNT_ZERO;
      end else begin
        count_next = count_value + 16'h0001;
      end
    end
    // Capture trigger from synchronized edge; short pulses may be missed
    if (running && edge_hit && capture_ctrl_reg[`TMCC_CAP_A_BIT]) begin
      compare_a_next = count_value;
    end
    if (running && edge_hit && capture_ctrl_reg[`TMCC_CAP_B_BIT]) begin
      compare_b_next = count_value;
    end
    if (output_ctrl_reg[`TMCC_OUT_ENABLE_BIT] && tick && (match_a || match_b)) begin
      if (output_ctrl_reg[`TMCC_OUT_MODE_BIT]) begin
        out_ff_next = match_b ? 1'b1 : 1'b0;
      end else begin
        out_ff_next = ~out_ff_reg;
      end
      if (os_active_reg && match_a) begin
        os_active_next = 1'b0;
      end
    end
    if (rd) begin
      if (addr == `TMCC_OFF_MODE) begin
        rdata_next = {8'h00, mode_ctrl_reg};
      end else if (addr == `TMCC_OFF_CAPCTL) begin
        rdata_next = {8'h00, capture_ctrl_reg};
      end else if (addr == `TMCC_OFF_OUTCTL) begin
        rdata_next = {8'h00, output_ctrl_reg};
      end else if (addr == `TMCC_OFF_PRESC) begin
        rdata_next = {8'h00, prescaler_mode_reg};
      end else if (addr == `TMCC_OFF_CMPA) begin
        rdata_next = compare_reg_a;
      end else if (addr == `TMCC_OFF_CMPB) begin
        rdata_next = compare_reg_b;
      end else if (addr == `TMCC_OFF_COUNT) begin
        rdata_next = count_value;
      end else if (addr == `TMCC_OFF_IRQ_STAT) begin
        rdata_next = {12'h000, irq_stat_reg};
        irq_stat_next = 4'h0;
      end else if (addr == `TMCC_OFF_IRQ_MASK) begin
        rdata_next = {12'h000, irq_mask_reg};
      end
    end
    // Events after clears so a set wins
    if (match_a) begin
      irq_stat_next[`TMCC_IRQ_MATCH_A_BIT] = 1'b1;
    end
    if (match_b) begin
      irq_stat_next[`TMCC_IRQ_MATCH_B_BIT] = 1'b1;
    end
    // Capture status set after the read clear so a capture into compare B is never lost
    if (running && edge_hit && capture_ctrl_reg[`TMCC_CAP_B_BIT]) begin
      irq_stat_next[`TMCC_IRQ_CAP_BIT] = 1'b1;
    end
    if (wrap && compare_reg_a == `TMCC_COUNT_MAX && op != TMCC_OP_STOP) begin
      mode_ctrl_next[`TMCC_MODE_OVF_BIT] = 1'b1;
      irq_stat_next[`TMCC_IRQ_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ctrl_reg <= 8'h00;
      capture_ctrl_reg <= 8'h00;
      output_ctrl_reg <= 8'h00;
      prescaler_mode_reg <= 8'h00;
      compare_reg_a <= '0;
      compare_reg_b <= '0;
      count_value <= '0;
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      rdata_reg <= 16'h0000;
      div_reg <= 8'h00;
      in_sync_reg <= 3'h0;
      out_ff_reg <= 1'b0;
      os_active_reg <= 1'b0;
    end else begin
      mode_ctrl_reg <= mode_ctrl_next;
      capture_ctrl_reg <= capture_ctrl_next;
      output_ctrl_reg <= output_ctrl_next;
      prescaler_mode_reg <= prescaler_mode_next;
      compare_reg_a <= compare_a_next;
      compare_reg_b <= compare_b_next;
      count_value <= count_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
      div_reg <= div_next;
      in_sync_reg <= {in_sync_reg[1:0], ext_edge_input_a};
      out_ff_reg <= out_ff_next;
      os_active_reg <= os_active_next;
    end
  end

  assign rdata = rdata_reg;
  assign shared_port_pin = out_ff_reg & output_ctrl_reg[`TMCC_OUT_ENABLE_BIT];
  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ==== tmcc_timer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmcc_map.svh"
module tmcc_timer_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`TMCC_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic internal_ring_oscillator_sel,
  input wire logic ext_edge_input_a,
  input wire logic shared_port_pin,
  input wire logic irq
);
  logic [1:0] op_reg;
  logic [2:0] presc_reg;
  logic oe_reg;
  // Mirrors of written fields, since only ports are visible
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_reg <= 2'h0;
      presc_reg <= 3'h0;
      oe_reg <= 1'b0;
    end else if (wr) begin
      if (addr == 4'h0) op_reg <= wdata[3:2];
      if (addr == 4'h3) presc_reg <= wdata[2:0];
      if (addr == 4'h2) oe_reg <= wdata[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_idle_read_zero: assert property (!rd |=> rdata == 16'h0000)
    else $error("rdata not zero outside read");
  a_force_read_zero: assert property (rd && addr == 4'h2 |=> rdata[3:2] == 2'h0)
    else $error("force bits read nonzero");
  a_trig_read_zero: assert property (rd && addr == 4'h2 |=> !rdata[6])
    else $error("trigger bit read nonzero");
  a_stop_count_frozen: assert property (op_reg == 2'h0 && rd && addr == 4'h6 ##1
    rd && addr == 4'h6 |=> rdata == $past(rdata))
    else $error("count moved while stopped");
  a_run_count_step: assert property (op_reg == 2'h2 && rd && addr == 4'h6 &&
    (presc_reg == 3'h0 || (presc_reg == 3'h7 && internal_ring_oscillator_sel)) ##1 rd && addr == 4'h6
    |=> rdata == $past(rdata) + 16'h0001)
    else $error("count did not step each clock");
  a_ovf_clear: assert property (wr && addr == 4'h0 && wdata[3:0] == 4'h0 ##[1:2]
    rd && addr == 4'h0 |=> !rdata[0])
    else $error("overflow flag not cleared");
  // Pin is gated by a registered enable, so allow one cycle of lag
  a_pin_needs_enable: assert property (!oe_reg && !$past(oe_reg) |-> !shared_port_pin)
    else $error("pin high without enable");
endmodule
bind tmcc_timer tmcc_timer_asserts u_chk (.clock(clock), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .internal_ring_oscillator_sel(internal_ring_oscillator_sel),
  .ext_edge_input_a(ext_edge_input_a), .shared_port_pin(shared_port_pin), .irq(irq));
`default_nettype wire

// ==== tmcc_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmcc_pin_model (
  input wire logic clock,
  input wire logic shared_port_pin,
  output logic ext_edge_input_a
);
  int hold = 8;
  initial ext_edge_input_a = 1'b0;
  // Level held well past the count clock so the capture is reliable
  task automatic drive(input logic lv);
    @(posedge clock);
    ext_edge_input_a <= lv;
    repeat (hold) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ==== test_timer16_control_output_cautions.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_timer16_control_output_cautions;
  logic clock, rst, wr, rd, internal_ring_oscillator_sel, ext_edge_input_a, shared_port_pin, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, v1, v2;
  logic [15:0] mdl [16];
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  tmcc_timer u_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .internal_ring_oscillator_sel(internal_ring_oscillator_sel), .ext_edge_input_a(ext_edge_input_a),
    .shared_port_pin(shared_port_pin), .irq(irq));
  tmcc_pin_model u_pin (.clock(clock), .shared_port_pin(shared_port_pin),
    .ext_edge_input_a(ext_edge_input_a));
  function automatic logic [15:0] rmask(input logic [3:0] a);
    case (a)
      4'h0: return 16'h000D;
      4'h1: return 16'h0003;
      4'h2: return 16'h0033;
      4'h3: return 16'h0037;
      4'h4, 4'h5: return 16'hFFFF;
      default: return 16'h0000;
    endcase
  endfunction
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    mdl[a] = d & rmask(a);
  endtask
  // Two back-to-back reads; count, status and mask are not modelled
  task rreg(input logic [3:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    @(negedge clock);
    v1 = rdata;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v2 = rdata;
    if (a < 4'h6 || a > 4'h8) check("readback", v1, mdl[a]);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    internal_ring_oscillator_sel = 1'b0;
    foreach (mdl[i]) mdl[i] = 16'h0000;
    void'($urandom(32'hF127));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rreg(i[3:0]);
      check("reset", v1, 16'h0000);
    end
    $display("reset test done");
    wreg(4'h5, 16'($urandom()));
    rreg(4'h5);
    wreg(4'h2, 16'h0021);
    wreg(4'h2, 16'h0065);
    rreg(4'h2);
    check("pin set", 16'(shared_port_pin), 16'h0001);
    wreg(4'h2, 16'h0029);
    repeat (2) @(posedge clock);
    check("pin reset", 16'(shared_port_pin), 16'h0000);
    wreg(4'h2, 16'h0000);
    $display("output test done");
    wreg(4'h8, 16'h0008);
    for (int e = 0; e < 4; e++) begin
      wreg(4'h0, 16'h0000);
      wreg(4'h3, 16'(e << 4));
      wreg(4'h1, 16'h0002);
      wreg(4'h0, 16'h0008);
      rreg(4'h7);
      u_pin.drive(1'b1);
      check("irq rise", 16'(irq), 16'(e == 1 || e == 3));
      rreg(4'h7);
      u_pin.drive(1'b0);
      check("irq fall", 16'(irq), 16'(e == 0 || e == 3));
      rreg(4'h7);
    end
    $display("edge test done");
    wreg(4'h0, 16'h0000);
    wreg(4'h8, 16'h0001);
    wreg(4'h4, 16'hFFFF);
    wreg(4'h1, 16'h0000);
    wreg(4'h3, 16'h0007);
    internal_ring_oscillator_sel <= 1'b1;
    rreg(4'h7);
    wreg(4'h0, 16'h0008);
    rreg(4'h6);
    check("count step", v2, v1 + 16'h0001);
    for (int i = 0; i < 70000 && irq !== 1'b1; i++) @(posedge clock);
    check("ovf irq", 16'(irq), 16'h0001);
    mdl[0][0] = 1'b1;
    rreg(4'h0);
    wreg(4'h0, 16'h0000);
    rreg(4'h0);
    rreg(4'h6);
    check("stopped", v2, v1);
    rreg(4'h7);
    check("irq clear", 16'(irq), 16'h0000);
    $display("overflow test done");
    wreg(4'h3, 16'h0000);
    wreg(4'h4, 16'h0004);
    wreg(4'h1, 16'h0000);
    wreg(4'h0, 16'h000C);
    // Read period 3 against a cycle of 5 walks every phase
    for (int k = 0; k < 5; k++) begin
      rreg(4'h6);
      check("match range", 16'(v1 <= 16'h0004), 16'h0001);
      check("match clear", v2, (v1 == 16'h0004) ? 16'h0000 : v1 + 16'h0001);
    end
    wreg(4'h0, 16'h0000);
    wreg(4'h3, 16'h0010);
    wreg(4'h0, 16'h0004);
    repeat (100) @(posedge clock);
    u_pin.drive(1'b1);
    rreg(4'h6);
    check("edge clear", 16'(v1 < 16'h0010), 16'h0001);
    u_pin.drive(1'b0);
    wreg(4'h0, 16'h0000);
    $display("clear mode test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
